//--- core/panel_meter_bcd_output_interface.sv
// Overview of operation
// R1: blank input low blanks digits and sign
// R2: unblanking shows stored reading at once
// R3: hold low stops conversion, keeps last result
// R4: releasing hold restarts repeating conversions
// R5: each low point select lights its point
// R6: status high converting, low when outputs valid
// R7: polarity high when positive, latched per result
// R8: latched overload when magnitude reaches full count
// R9: overload blanks digits, sign stays valid
// R10: four shared bcd lines, five digit strobes
// R11: bcd lines belong to the strobed digit
// R12: multiplexed data valid in window, status low
// R13: parallel option latches all digits together
// R14: parallel data valid while data ready high
// R15: parallel latches load about 5 ms later
// R16: conversion 180 ms, overload 210 ms; the code holds status high 150 ms, 180 ms on overload
// R17: free running at five results per second
// R18: digits coded 8-4-2-1 on bit lines
`timescale 1ns/1ps
`default_nettype none

module panel_meter_bcd_output_interface
	import panel_meter_pkg::*;
#(
	parameter int unsigned BUSY_CYCLES = BUSY_CYC,
	parameter int unsigned OVL_CYCLES = OVL_CYC,
	parameter int unsigned WIN_CYCLES = WIN_CYC,
	parameter int unsigned LOAD_CYCLES = LOAD_CYC,
	parameter int unsigned DIGIT_CYCLES = DIGIT_CYC,
	parameter bit PAR_EN = 1'b1
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic hold_n,
	input wire logic blank_n,
	input wire logic [NDP-1:0] decimal_point_select_n,
	input wire logic [MAG_W-1:0] mag_in,
	input wire logic positive_in,
	output logic status,
	output logic polarity,
	output logic overload,
	output logic [BCD_W-1:0] bcd,
	output logic [NDIG-1:0] digit_strobe,
	output logic [NDIG*BCD_W-1:0] disp_bcd,
	output logic digits_on,
	output logic sign_on,
	output logic [NDP-1:0] dp_on,
	output logic [NDIG*BCD_W-1:0] par_bcd,
	output logic par_polarity,
	output logic data_ready
);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	localparam int unsigned SYN_W = NDP + 2;

	logic [SYN_W-1:0] syn1_r;
	logic [SYN_W-1:0] syn2_r;
	wire logic [SYN_W-1:0] pins_raw;
	wire logic hold_on;
	wire logic blank_ok;
	wire logic [NDP-1:0] dp_sel_n_s;

	assign pins_raw = {hold_n, blank_n, decimal_point_select_n};
	assign hold_on = ~syn2_r[SYN_W-1];
	assign blank_ok = syn2_r[SYN_W-2];
	assign dp_sel_n_s = syn2_r[NDP-1:0];

	// open inputs float high, so reset to the inactive level
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			syn1_r <= '1;
			syn2_r <= '1;
		end else begin
			syn1_r <= pins_raw;
			syn2_r <= syn1_r;
		end
	end

	// ------------------------------------------------------------
	// binary to bcd
	// ------------------------------------------------------------
	function automatic logic [NDIG*BCD_W-1:0] to_bcd(
		input logic [MAG_W-1:0] v
	);
		logic [NDIG*BCD_W+MAG_W-1:0] s;
		s = {{(NDIG*BCD_W){1'b0}}, v};
		for (int i = 0; i < MAG_W; i++) begin
			for (int j = 0; j < NDIG; j++) begin
				if (s[MAG_W+BCD_W*j +: BCD_W] > BCD_ADJ_LIM)
					s[MAG_W+BCD_W*j +: BCD_W] =
						s[MAG_W+BCD_W*j +: BCD_W] + BCD_ADJ; // R18
			end
			s = s << 1;
		end
		return s[NDIG*BCD_W+MAG_W-1:MAG_W];
	endfunction

	// ------------------------------------------------------------
	// conversion sequencer
	// ------------------------------------------------------------
	conv_state_e st_r;
	conv_state_e st_nxt;
	logic [TMR_W-1:0] tmr_r;
	logic [TMR_W-1:0] tmr_nxt;
	logic [MAG_W-1:0] samp_mag_r;
	logic samp_pos_r;

	wire logic in_busy;
	wire logic in_ovl;
	wire logic in_win;
	wire logic busy_done;
	wire logic ovl_done;
	wire logic win_done;
	wire logic samp_ovl;
	wire logic abort;
	wire logic new_res;
	wire logic [MAG_W-1:0] res_mag;
	wire logic res_pos;

	assign in_busy = (st_r == ST_BUSY);
	assign in_ovl = (st_r == ST_OVL);
	assign in_win = (st_r == ST_WIN);
	assign busy_done = in_busy && tmr_r == TMR_W'(BUSY_CYCLES - 1); // R16
	assign ovl_done = in_ovl && tmr_r == TMR_W'(OVL_CYCLES - 1); // R16
	assign win_done = in_win && tmr_r >= TMR_W'(WIN_CYCLES - 1); // R12
	assign samp_ovl = (mag_in >= FULL_COUNT); // R8
	assign abort = (in_busy || in_ovl) && hold_on; // R3
	assign new_res = !hold_on
		&& ((busy_done && !samp_ovl) || ovl_done);
	assign res_mag = in_ovl ? samp_mag_r : mag_in;
	assign res_pos = in_ovl ? samp_pos_r : positive_in;

	always_comb begin
		st_nxt = st_r;
		tmr_nxt = tmr_r + TMR_W'(1);
		unique case (st_r)
			ST_BUSY: begin
				if (abort) begin
					st_nxt = ST_WIN;
					tmr_nxt = '0;
				end else if (busy_done) begin
					st_nxt = samp_ovl ? ST_OVL : ST_WIN; // R16
					tmr_nxt = '0;
				end
			end
			ST_OVL: begin
				if (abort || ovl_done) begin
					st_nxt = ST_WIN;
					tmr_nxt = '0;
				end
			end
			ST_WIN: begin
				if (win_done) begin
					tmr_nxt = tmr_r;
					// a low hold parks here, data stays valid
					if (!hold_on) begin
						st_nxt = ST_BUSY; // R4 R17
						tmr_nxt = '0;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= ST_BUSY;
			tmr_r <= '0;
		end else begin
			st_r <= st_nxt;
			tmr_r <= tmr_nxt;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			samp_mag_r <= '0;
			samp_pos_r <= 1'b0;
		end else if (busy_done) begin
			samp_mag_r <= mag_in;
			samp_pos_r <= positive_in;
		end
	end

	// ------------------------------------------------------------
	// latched result
	// ------------------------------------------------------------
	logic [NDIG*BCD_W-1:0] res_bcd_r;
	logic pol_r;
	logic ovl_r;
	wire logic [NDIG*BCD_W-1:0] res_bcd_nxt;
	wire logic ovl_nxt;

	assign res_bcd_nxt = new_res ? to_bcd(res_mag) : res_bcd_r;
	assign ovl_nxt = new_res ? (res_mag >= FULL_COUNT) : ovl_r;

	// result, sign and flag change together on the edge status drops
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			res_bcd_r <= '0;
			pol_r <= 1'b0;
			ovl_r <= 1'b0;
		end else if (new_res) begin
			res_bcd_r <= res_bcd_nxt;
			pol_r <= res_pos; // R7
			ovl_r <= ovl_nxt; // R8
		end
	end

	assign polarity = pol_r;
	assign overload = ovl_r;

	// ------------------------------------------------------------
	// digit scan
	// ------------------------------------------------------------
	logic [DIG_IDX_W-1:0] idx_r;
	logic [DIG_IDX_W-1:0] idx_nxt;
	logic [TMR_W-1:0] dtmr_r;
	logic [TMR_W-1:0] dtmr_nxt;
	wire logic win_nxt;
	wire logic dig_step;
	wire logic [NDIG-1:0] strobe_nxt;
	wire logic [BCD_W-1:0] bcd_nxt;

	assign win_nxt = (st_nxt == ST_WIN);
	assign dig_step = dtmr_r == TMR_W'(DIGIT_CYCLES - 1);

	always_comb begin
		idx_nxt = '0;
		dtmr_nxt = '0;
		if (win_nxt && in_win) begin
			dtmr_nxt = dig_step ? '0 : dtmr_r + TMR_W'(1);
			idx_nxt = idx_r;
			if (dig_step)
				idx_nxt = (idx_r == DIG_IDX_W'(NDIG - 1))
					? '0 : idx_r + DIG_IDX_W'(1); // R10
		end
	end

	for (genvar g = 0; g < NDIG; g++) begin : g_strobe
		assign strobe_nxt[g] = win_nxt
			&& idx_nxt == DIG_IDX_W'(g); // R10 R11 R12
	end

	// bit lines carry only the digit whose strobe rises with them
	assign bcd_nxt = win_nxt
		? res_bcd_nxt[BCD_W*idx_nxt +: BCD_W] : '0; // R11 R18

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			idx_r <= '0;
			dtmr_r <= '0;
			digit_strobe <= '0;
			bcd <= '0;
			status <= 1'b1;
		end else begin
			idx_r <= idx_nxt;
			dtmr_r <= dtmr_nxt;
			digit_strobe <= strobe_nxt;
			bcd <= bcd_nxt;
			status <= !win_nxt; // R6
		end
	end

	// ------------------------------------------------------------
	// display drive
	// ------------------------------------------------------------
	// stored reading is always present, so unblanking needs no wait
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			disp_bcd <= '0;
			digits_on <= 1'b0;
			sign_on <= 1'b0;
			dp_on <= '0;
		end else begin
			disp_bcd <= res_bcd_nxt; // R2 R3
			digits_on <= blank_ok && !ovl_nxt; // R1 R2 R9
			sign_on <= blank_ok; // R1 R9
			dp_on <= ~dp_sel_n_s; // R1 R5
		end
	end

	// ------------------------------------------------------------
	// parallel output option
	// ------------------------------------------------------------
	logic load_pend_r;
	logic [TMR_W-1:0] ltmr_r;
	wire logic load_done;

	assign load_done = load_pend_r
		&& ltmr_r == TMR_W'(LOAD_CYCLES - 1); // R15

	// a held meter keeps the old latches and data ready untouched
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			load_pend_r <= 1'b0;
			ltmr_r <= '0;
			par_bcd <= '0;
			par_polarity <= 1'b0;
			data_ready <= 1'b0;
		end else if (!PAR_EN) begin
			data_ready <= 1'b0;
		end else if (new_res) begin
			load_pend_r <= 1'b1;
			ltmr_r <= '0;
			data_ready <= 1'b0; // R14
		end else if (load_done) begin
			load_pend_r <= 1'b0;
			par_bcd <= res_bcd_r; // R13
			par_polarity <= pol_r; // R13
			data_ready <= 1'b1; // R14
		end else if (load_pend_r) begin
			ltmr_r <= ltmr_r + TMR_W'(1);
		end
	end

endmodule

`default_nettype wire

//--- common/panel_meter_pkg.sv
package panel_meter_pkg;

	// ------------------------------------------------------------
	// clock and timing figures
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	localparam int unsigned RATE_HZ = 5;
	localparam int unsigned WIN_MS = 50;
	localparam int unsigned CONV_FS_MS = 180;
	localparam int unsigned CONV_OVL_MS = 210;
	localparam int unsigned LOAD_MS = 5;
	localparam int unsigned DIGIT_MS = 1;

	localparam int unsigned PERIOD_CYC = CLK_HZ / RATE_HZ;
	localparam int unsigned WIN_CYC = WIN_MS * CYC_PER_MS;
	localparam int unsigned BUSY_CYC = PERIOD_CYC - WIN_CYC;
	localparam int unsigned OVL_CYC = (CONV_OVL_MS - CONV_FS_MS) * CYC_PER_MS;
	localparam int unsigned LOAD_CYC = LOAD_MS * CYC_PER_MS;
	localparam int unsigned DIGIT_CYC = DIGIT_MS * CYC_PER_MS;

	// ------------------------------------------------------------
	// data layout
	// ------------------------------------------------------------
	localparam int unsigned NDIG = 5;
	localparam int unsigned BCD_W = 4;
	localparam int unsigned MAG_W = 15;
	localparam int unsigned NDP = 4;
	localparam int unsigned TMR_W = 23;
	localparam int unsigned DIG_IDX_W = 3;
	localparam logic [MAG_W-1:0] FULL_COUNT = 15'h4E20;
	localparam logic [BCD_W-1:0] BCD_ADJ_LIM = 4'h4;
	localparam logic [BCD_W-1:0] BCD_ADJ = 4'h3;

	typedef enum logic [1:0] {
		ST_BUSY,
		ST_OVL,
		ST_WIN
	} conv_state_e;

endpackage

//--- dv/panel_meter_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// port checker
// ----
module panel_meter_sva #(
	parameter int unsigned W = 30
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic hold_n,
	input wire logic blank_n,
	input wire logic [3:0] decimal_point_select_n,
	input wire logic status,
	input wire logic polarity,
	input wire logic overload,
	input wire logic [3:0] bcd,
	input wire logic [4:0] digit_strobe,
	input wire logic digits_on,
	input wire logic sign_on,
	input wire logic [3:0] dp_on,
	input wire logic [19:0] par_bcd,
	input wire logic data_ready
);
	int unsigned low_r;
	// counts sampled low cycles of status, so the window length is checked
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			low_r <= 32'h0;
		else
			low_r <= status ? 32'h0 : low_r + 32'h1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	idle_lines_a: assert property (
		status |-> bcd == 4'h0 && digit_strobe == 5'h00)
		else $error("digit lines active while converting");
	one_strobe_a: assert property (
		!status |-> $onehot(digit_strobe))
		else $error("not exactly one strobe in window");
	first_digit_a: assert property (
		$fell(status) |-> digit_strobe == 5'h01)
		else $error("scan does not start at units digit");
	window_len_a: assert property (
		$rose(status) && $past(nrst) |-> low_r >= W)
		else $error("data window too short");
	result_kept_a: assert property (
		!status [*2] |-> $stable({polarity, overload}))
		else $error("polarity or overload moved in window");
	point_sel_a: assert property (
		$stable(decimal_point_select_n) [*5]
		|-> dp_on == ~decimal_point_select_n)
		else $error("decimal point does not follow select");
	sign_blank_a: assert property (
		$stable(blank_n) [*5] |-> sign_on == blank_n)
		else $error("sign does not follow blank input");
	digit_blank_a: assert property (
		$stable({blank_n, overload}) [*5]
		|-> digits_on == (blank_n && !overload))
		else $error("digit lighting wrong");
	load_delay_a: assert property (
		$fell(data_ready) |-> !data_ready [*5] ##1 data_ready)
		else $error("parallel load delay wrong");
	par_stable_a: assert property (
		data_ready [*2] |-> $stable(par_bcd))
		else $error("parallel data moved while ready");
	cover property ($fell(status) && overload);
	cover property ($rose(data_ready));
	cover property (!hold_n && !status);
endmodule
bind panel_meter_bcd_output_interface panel_meter_sva #(.W(WIN_CYCLES)) sva (
	.clk(clk), .nrst(nrst), .hold_n(hold_n), .blank_n(blank_n),
	.decimal_point_select_n(decimal_point_select_n), .status(status),
	.polarity(polarity), .overload(overload), .bcd(bcd),
	.digit_strobe(digit_strobe), .digits_on(digits_on), .sign_on(sign_on),
	.dp_on(dp_on), .par_bcd(par_bcd), .data_ready(data_ready));
`default_nettype wire

//--- dv/bcd_capture.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// capture logic on the serial digit lines
// ----
module bcd_capture (
	input wire logic clk,
	input wire logic nrst,
	input wire logic status,
	input wire logic [3:0] bcd,
	input wire logic [4:0] digit_strobe,
	output logic [19:0] cap,
	output logic cap_v
);
	logic [4:0] seen_r;
	logic done_r;
	// one capture per window, rescans of the same window are ignored
	assign cap_v = &seen_r && !done_r;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			seen_r <= 5'h00;
			done_r <= 1'b0;
			cap <= 20'h00000;
		end else if (status) begin
			seen_r <= 5'h00;
			done_r <= 1'b0;
		end else begin
			for (int i = 0; i < 5; i++)
				if (digit_strobe[i])
					cap[4*i+:4] <= bcd;
			seen_r <= seen_r | digit_strobe;
			done_r <= done_r | cap_v;
		end
	end
endmodule
`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// bench
// ----
module testbench;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic hold_n = 1'b1;
	logic blank_n = 1'b1;
	logic [3:0] dp_n = 4'hF;
	logic [14:0] mag = 15'h0000;
	logic pos = 1'b1;
	logic p, status, polarity, overload, par_polarity, data_ready, cap_v, dr_r;
	logic [3:0] bcd;
	logic [4:0] digit_strobe;
	logic [19:0] par_bcd, cap;
	logic [21:0] qs[$], qp[$], exp_v, last_v, want_s;
	logic digits_on, sign_on;
	logic [3:0] dp_on;
	logic [5:0] lamps_w;
	logic [19:0] disp_bcd;
	int miscompares = 0;
	int compares = 0;
	int unsigned m;
	int unsigned tbl[4] = '{0, 19999, 20000, 32767};
	initial forever #25 clk = ~clk;
	panel_meter_bcd_output_interface #(.BUSY_CYCLES(40), .OVL_CYCLES(8),
		.WIN_CYCLES(30), .LOAD_CYCLES(5), .DIGIT_CYCLES(3)) dut (
		.clk(clk), .nrst(nrst), .hold_n(hold_n), .blank_n(blank_n),
		.decimal_point_select_n(dp_n), .mag_in(mag), .positive_in(pos),
		.status(status), .polarity(polarity), .overload(overload), .bcd(bcd),
		.digit_strobe(digit_strobe), .disp_bcd(disp_bcd),
		.digits_on(digits_on), .sign_on(sign_on),
		.dp_on(dp_on), .par_bcd(par_bcd), .par_polarity(par_polarity),
		.data_ready(data_ready));
	bcd_capture cap_m (.clk(clk), .nrst(nrst), .status(status), .bcd(bcd),
		.digit_strobe(digit_strobe), .cap(cap), .cap_v(cap_v));
	task automatic check(logic [21:0] got, logic [21:0] want);
		compares++;
		if (got !== want) begin
			miscompares++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, want);
		end
	endtask
	task automatic check_par(logic [21:0] got, logic [21:0] want);
		compares++;
		if (got !== want) begin
			miscompares++;
			$display("CHECK FAILED %0t parallel %h want %h", $time, got, want);
		end
	endtask
	task automatic check_disp(logic [19:0] got, logic [19:0] want);
		compares++;
		if (got !== want) begin
			miscompares++;
			$display("CHECK FAILED %0t display %h want %h", $time, got, want);
		end
	endtask
	task automatic check_lamps(logic [5:0] got, logic [5:0] want);
		compares++;
		if (got !== want) begin
			miscompares++;
			$display("CHECK FAILED %0t lamps %h want %h", $time, got, want);
		end
	endtask
	task automatic tally_and_finish();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic wait_st(logic v);
		for (int n = 0; status !== v; n++) begin
			@(negedge clk);
			if (n > 2000) begin
				miscompares++;
				tally_and_finish();
			end
		end
	endtask
	function automatic logic [21:0] expect_of(int unsigned v, logic s);
		logic [21:0] r;
		r = {s, v >= 20000, 20'h00000};
		for (int k = 0; k < 5; k++)
			r[4*k+:4] = 4'((v / (10 ** k)) % 10);
		return r;
	endfunction
	// results are judged settled, half a cycle after the edge
	always @(negedge clk) begin
		// pins settle long before the scan ends, so lamps are judged here
		if (cap_v === 1'b1) begin
			want_s = qs.pop_front();
			lamps_w = {blank_n && !want_s[20], blank_n, ~dp_n};
			check({polarity, overload, cap}, want_s);
			check_disp(disp_bcd, want_s[19:0]);
			check_lamps({digits_on, sign_on, dp_on}, lamps_w);
		end
		if (data_ready === 1'b1 && dr_r !== 1'b1)
			check_par({par_polarity, overload, par_bcd},
				qp.pop_front());
		dr_r = data_ready;
	end
	initial begin
		m = $urandom(32'h494B);
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			wait_st(1'b1);
			@(posedge clk);
			m = (i < 4) ? tbl[i] : $urandom % 24000;
			p = 1'($urandom);
			mag <= 15'(m);
			pos <= p;
			dp_n <= 4'($urandom);
			blank_n <= (i % 3 != 1);
			exp_v = expect_of(m, p);
			if (i == 5) begin
				repeat (10) @(posedge clk);
				hold_n <= 1'b0;
				qs.push_back(last_v);
				repeat (45) @(posedge clk);
				hold_n <= 1'b1;
			end else begin
				qs.push_back(exp_v);
				qp.push_back(exp_v);
				last_v = exp_v;
			end
			wait_st(1'b0);
		end
		for (int n = 0; n < 200 && qs.size() + qp.size() > 0; n++)
			@(negedge clk);
		if (qs.size() + qp.size() > 0)
			miscompares++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
